/* File: rtl/acl_ctrl.sv */
/*
 Command-list sequencing control of an analog-to-digital converter with AXI4-Lite registers.
 Assumes triggers, restarts, mode indications and error events arrive from other domains.
*/
`timescale 1ns/1ps
module acl_ctrl
   import acl_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire acl_evt_t    evt_in,
   input  wire logic        conv_done,
   output logic             conv_start,
   output logic             analog_on,
   output logic [15:0]      conv_flag_pulse,
   output logic [7:0]       command_index
);
   typedef enum logic [2:0] {
      ACL_OFF, ACL_DRAIN, ACL_RECOVER, ACL_IDLE, ACL_FETCH, ACL_CONV, ACL_WAIT_RST, ACL_ERR
   } acl_state_t;

   acl_state_t  state_r;
   logic [15:0] ctl0_r;
   logic [4:0]  ctl1_r;
   logic [31:0] cmd_r;
   logic [15:0] flags_r;
   logic [3:0]  err_r;
   logic [7:0]  ovr_r;
   logic [31:0] cbp_r;
   logic [15:0] coff_r;
   logic [7:0]  ridx_r;
   logic [CNT_W-1:0] cnt_r;
   logic [1:0]  srst_cnt_r;
   logic        aw_hold_r;
   logic        w_hold_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   acl_evt_t    evt_s;
   logic        trig_d_r;
   logic        rst_d_r;
   logic        trig_edge;
   logic        rst_edge;
   logic        wr_go;
   logic        aw_take;
   logic        w_take;
   logic        en;
   logic        smod;
   logic        cfg_wr_ok;
   logic        halt_req;
   logic [15:0] wmask;
   logic [31:0] rd_val;
   acl_cmd_t    cur_cmd;

   genvar g;
   generate
      for (g = 0; g < 8; g = g + 1) begin : g_sync
         acl_sync u_sync (
            .aclk    (aclk),
            .aresetn (aresetn),
            .din     (evt_in[g]),
            .dout    (evt_s[g])
         );
      end
   endgenerate

   assign trig_edge = evt_s.trig & ~trig_d_r;
   assign rst_edge  = evt_s.restart & ~rst_d_r;
   assign en        = ctl0_r[B_EN];
   assign smod      = ctl1_r[B_SMOD];
   assign cfg_wr_ok = ~en | smod;
   assign halt_req  = (ctl0_r[B_FRZ] & evt_s.freeze) | (ctl0_r[B_WAI] & evt_s.wait_mode);
   assign aw_take   = s_axi_awvalid & s_axi_awready;
   assign w_take    = s_axi_wvalid & s_axi_wready;
   // A write completes once both halves are taken; the pending response blocks the next one.
   assign wr_go     = (aw_hold_r | aw_take) & (w_hold_r | w_take) & ~s_axi_bvalid;
   assign cur_cmd   = '{cmd_type: cmd_r[CT_HI:CT_LO], flag_sel: cmd_r[FS_HI:FS_LO]};

   logic [7:0]  wa;
   logic [31:0] wd;
   logic [3:0]  ws;
   logic [15:0] wd16;
   assign wa   = aw_hold_r ? awaddr_r : s_axi_awaddr;
   assign wd   = w_hold_r ? wdata_r : s_axi_wdata;
   assign ws   = w_hold_r ? wstrb_r : s_axi_wstrb;
   assign wd16 = {ws[1] ? wd[15:8] : ctl0_r[15:8], ws[0] ? wd[7:0] : ctl0_r[7:0]};
   assign wmask = CTL0_WR_ANY | (cfg_wr_ok ? CTL0_WR_CFG : 16'h0000);

   // Write channel capture: address and data may arrive in either order.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r     <= 1'b0;
         w_hold_r      <= 1'b0;
         awaddr_r      <= 8'h00;
         wdata_r       <= 32'h0000_0000;
         wstrb_r       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_hold_r & ~s_axi_awready & s_axi_awvalid & ~s_axi_bvalid;
         s_axi_wready  <= ~w_hold_r & ~s_axi_wready & s_axi_wvalid & ~s_axi_bvalid;
         if (aw_take) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (w_take) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go) begin
            aw_hold_r    <= 1'b0;
            w_hold_r     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (wa)
               OFF_CTL0, OFF_CTL1, OFF_CMD0, OFF_STAT, OFF_FLAGS, OFF_ERR,
               OFF_CBP, OFF_COFF, OFF_CIDX: s_axi_bresp <= RESP_OKAY;
               default: s_axi_bresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic do_wr;
   assign do_wr = wr_go;

   // Control registers.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl0_r <= 16'h0000;
         ctl1_r <= 5'h00;
         cmd_r  <= 32'h0000_0000;
         cbp_r  <= 32'h0000_0000;
         coff_r <= 16'h0000;
      end else begin
         if (do_wr && wa == OFF_CTL0) begin
            ctl0_r <= (ctl0_r & ~wmask) | (wd16 & wmask);
            ctl0_r[B_SR] <= ctl0_r[B_SR] | wd16[B_SR];
            if (!en && wd16[B_EN] && state_r != ACL_OFF) begin
               ctl0_r[B_EN] <= 1'b0;
            end
         end else if (ctl0_r[B_SR] && srst_cnt_r == SRST_CYCLES[1:0]) begin
            ctl0_r[B_SR] <= 1'b0;
         end
         if (do_wr && wa == OFF_CTL1 && ws[0]) begin
            ctl1_r[B_SMOD]    <= wd[B_SMOD];
            ctl1_r[B_RSTMODE] <= wd[B_RSTMODE];
            if (cfg_wr_ok) begin
               ctl1_r[B_BMOD] <= wd[B_BMOD];
            end
            if (!en) begin
               ctl1_r[B_CSLSEL] <= wd[B_CSLSEL] & wd[B_BMOD];
               ctl1_r[B_RVLSEL] <= wd[B_RVLSEL];
            end
         end else if (ctl0_r[B_SR] && srst_cnt_r == SRST_CYCLES[1:0]) begin
            ctl1_r[B_CSLSEL] <= 1'b0;
            ctl1_r[B_RVLSEL] <= 1'b0;
         end else if (!ctl1_r[B_BMOD]) begin
            ctl1_r[B_CSLSEL] <= 1'b0;
         end
         if (do_wr && wa == OFF_CMD0 && smod) begin
            cmd_r <= wd;
         end
         if (do_wr && wa == OFF_CBP && !en) begin
            cbp_r <= wd;
         end
         if (do_wr && wa == OFF_COFF && !en) begin
            coff_r <= wd[15:0];
         end
      end
   end

   // Sequencer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r         <= ACL_OFF;
         cnt_r           <= '0;
         srst_cnt_r      <= 2'h0;
         command_index   <= 8'h00;
         ridx_r          <= 8'h00;
         conv_start      <= 1'b0;
         conv_flag_pulse <= 16'h0000;
         analog_on       <= 1'b0;
         trig_d_r        <= 1'b0;
         rst_d_r         <= 1'b0;
      end else begin
         trig_d_r        <= evt_s.trig;
         rst_d_r         <= evt_s.restart;
         conv_start      <= 1'b0;
         conv_flag_pulse <= 16'h0000;
         analog_on       <= en;
         srst_cnt_r      <= (ctl0_r[B_SR] && srst_cnt_r != SRST_CYCLES[1:0]) ?
                            srst_cnt_r + 2'h1 : 2'h0;
         if (do_wr && wa == OFF_CIDX && !en) begin
            command_index <= wd[7:0];
         end
         if (ctl0_r[B_SR] && srst_cnt_r == SRST_CYCLES[1:0]) begin
            // Draining and recovery keep their own timing so a soft reset cannot shorten them.
            if (state_r != ACL_DRAIN && state_r != ACL_RECOVER) begin
               state_r <= en ? ACL_IDLE : ACL_OFF;
            end
            command_index <= 8'h00;
            ridx_r        <= 8'h00;
         end else if (!en && state_r != ACL_OFF && state_r != ACL_DRAIN) begin
            state_r <= ACL_DRAIN;
            cnt_r   <= CNT_W'(DIS_CYCLES);
         end else if (|err_r && state_r != ACL_OFF && state_r != ACL_DRAIN) begin
            state_r <= ACL_ERR;
         end else begin
            case (state_r)
               ACL_OFF: begin
                  if (en) begin
                     state_r <= ACL_RECOVER;
                     cnt_r   <= CNT_W'(REC_CYCLES);
                  end
               end
               ACL_DRAIN: begin
                  if (cnt_r == '0) begin
                     state_r <= ACL_OFF;
                  end else begin
                     cnt_r <= cnt_r - 1'b1;
                  end
               end
               ACL_RECOVER: begin
                  if (cnt_r == '0) begin
                     state_r <= ACL_IDLE;
                  end else begin
                     cnt_r <= cnt_r - 1'b1;
                  end
               end
               ACL_IDLE: begin
                  if (trig_edge && !halt_req) begin
                     state_r <= ACL_FETCH;
                  end
               end
               ACL_FETCH: begin
                  if (!halt_req) begin
                     conv_start <= 1'b1;
                     state_r    <= ACL_CONV;
                  end
               end
               ACL_CONV: begin
                  if (conv_done) begin
                     if (cur_cmd.flag_sel != 4'h0) begin
                        conv_flag_pulse[cur_cmd.flag_sel] <= 1'b1;
                     end
                     ridx_r <= ridx_r + 8'h01;
                     case (cur_cmd.cmd_type)
                        CMD_NORMAL: begin
                           command_index <= (command_index == IDX_MAX) ? 8'h00 :
                                            command_index + 8'h01;
                           state_r <= ACL_FETCH;
                        end
                        CMD_END_SEQ: begin
                           command_index <= command_index + 8'h01;
                           state_r <= ACL_IDLE;
                        end
                        CMD_END_WRAP: begin
                           command_index <= 8'h00;
                           state_r <= ACL_FETCH;
                        end
                        CMD_END_WAIT: begin
                           command_index <= 8'h00;
                           state_r <= ctl1_r[B_RSTMODE] ? ACL_WAIT_RST : ACL_IDLE;
                        end
                        default: state_r <= ACL_IDLE;
                     endcase
                  end
               end
               ACL_WAIT_RST: begin
                  if (rst_edge) begin
                     state_r <= ACL_IDLE;
                  end
               end
               ACL_ERR: state_r <= ACL_ERR;
               default: state_r <= ACL_OFF;
            endcase
            if (rst_edge && state_r == ACL_IDLE) begin
               command_index <= 8'h00;
            end
         end
      end
   end

   // Error and flag status; a new flag wins over a clear in the same cycle, but a soft reset wins over a new error.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         err_r   <= 4'h0;
         ovr_r   <= 8'h00;
         flags_r <= 16'h0000;
      end else begin
         if (ctl0_r[B_SR]) begin
            err_r <= 4'h0;
            ovr_r <= 8'h00;
         end else begin
            err_r <= err_r | (en ? evt_s.sev_err : 4'h0);
            if (trig_edge && state_r != ACL_IDLE && state_r != ACL_OFF &&
                state_r != ACL_RECOVER) begin
               ovr_r[0] <= 1'b1;
            end
         end
         if (do_wr && wa == OFF_FLAGS) begin
            flags_r <= (flags_r & ~wd[15:0]) | conv_flag_pulse;
         end else begin
            flags_r <= flags_r | conv_flag_pulse;
         end
      end
   end

   always_comb begin
      case (s_axi_araddr)
         OFF_CTL0:  rd_val = {16'h0000, ctl0_r};
         OFF_CTL1:  rd_val = {27'h0, ctl1_r};
         OFF_CMD0:  rd_val = cmd_r;
         OFF_STAT:  rd_val = {16'h0000, ridx_r, 5'h00, 3'(state_r)};
         OFF_FLAGS: rd_val = {16'h0000, flags_r};
         OFF_ERR:   rd_val = {20'h00000, ovr_r, err_r};
         OFF_CBP:   rd_val = cbp_r;
         OFF_COFF:  rd_val = {16'h0000, coff_r};
         OFF_CIDX:  rd_val = {24'h000000, command_index};
         default:   rd_val = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_val;
            case (s_axi_araddr)
               OFF_CTL0, OFF_CTL1, OFF_CMD0, OFF_STAT, OFF_FLAGS, OFF_ERR,
               OFF_CBP, OFF_COFF, OFF_CIDX: s_axi_rresp <= RESP_OKAY;
               default: s_axi_rresp <= RESP_SLVERR;
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

/* File: rtl/acl_pkg.sv */
/*
 Package for the converter command-list control block: register offsets, field positions,
 command codes, timing figures and bus types.
 Assumes a 250 MHz bus clock and a 32-bit AXI4-Lite register port.
*/
package acl_pkg;
   localparam int unsigned CLK_MHZ            = 250;
   localparam int unsigned REC_TIME_NS        = 1000;
   localparam int unsigned REC_CYCLES         = (REC_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam int unsigned DIS_TIME_NS        = 100;
   localparam int unsigned DIS_CYCLES         = (DIS_TIME_NS * CLK_MHZ) / 1000;
   localparam int unsigned CONV_CYCLES        = 16;
   localparam int unsigned SRST_CYCLES        = 2;
   localparam int unsigned CNT_W              = 12;

   localparam logic [7:0]  OFF_CTL0           = 8'h00;
   localparam logic [7:0]  OFF_CTL1           = 8'h04;
   localparam logic [7:0]  OFF_CMD0           = 8'h14;
   localparam logic [7:0]  OFF_STAT           = 8'h20;
   localparam logic [7:0]  OFF_FLAGS          = 8'h24;
   localparam logic [7:0]  OFF_ERR            = 8'h28;
   localparam logic [7:0]  OFF_CBP            = 8'h2C;
   localparam logic [7:0]  OFF_COFF           = 8'h30;
   localparam logic [7:0]  OFF_CIDX           = 8'h34;

   localparam int unsigned B_EN               = 15;
   localparam int unsigned B_SR               = 14;
   localparam int unsigned B_FRZ              = 13;
   localparam int unsigned B_WAI              = 12;
   localparam int unsigned B_MODE             = 6;
   localparam int unsigned B_STRSEQ           = 5;
   localparam int unsigned B_ACC_HI           = 1;
   localparam int unsigned B_ACC_LO           = 0;
   localparam int unsigned B_SMOD             = 0;
   localparam int unsigned B_BMOD             = 1;
   localparam int unsigned B_CSLSEL           = 2;
   localparam int unsigned B_RVLSEL           = 3;
   localparam int unsigned B_RSTMODE          = 4;
   localparam int unsigned CT_HI              = 31;
   localparam int unsigned CT_LO              = 30;
   localparam int unsigned FS_HI              = 27;
   localparam int unsigned FS_LO              = 24;

   localparam logic [1:0]  CMD_NORMAL         = 2'h0;
   localparam logic [1:0]  CMD_END_SEQ        = 2'h1;
   localparam logic [1:0]  CMD_END_WRAP       = 2'h2;
   localparam logic [1:0]  CMD_END_WAIT       = 2'h3;

   localparam logic [1:0]  RESP_OKAY          = 2'h0;
   localparam logic [1:0]  RESP_SLVERR        = 2'h2;
   localparam logic [15:0] CTL0_WR_ANY        = 16'hF000;
   localparam logic [15:0] CTL0_WR_CFG        = 16'h0063;
   localparam logic [7:0]  IDX_MAX            = 8'h3F;

   typedef struct packed {
      logic [1:0] cmd_type;
      logic [3:0] flag_sel;
   } acl_cmd_t;

   typedef struct packed {
      logic        trig;
      logic        restart;
      logic        freeze;
      logic        wait_mode;
      logic [3:0]  sev_err;
   } acl_evt_t;
endpackage

/* File: rtl/acl_sync.sv */
/*
 Three-stage synchroniser for one level from outside the clock domain.
 The output changes only once the second and third stages agree.
*/
`timescale 1ns/1ps
module acl_sync
   import acl_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic din,
   output logic      dout
);
   logic s1_r;
   logic s2_r;
   logic s3_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end else begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r) begin
            dout <= s3_r;
         end
      end
   end
endmodule

/* File: verif/acl_ctrl_checker.sv */
/*
 Concurrent checks on the ports of acl_ctrl.
 Assumes one clock domain and a front end that answers each launch once.
*/
`timescale 1ns/1ps
module acl_ctrl_checker
   import acl_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        s_axi_arvalid,
   input  wire logic        s_axi_arready,
   input  wire logic        s_axi_rvalid,
   input  wire logic        conv_done,
   input  wire logic        conv_start,
   input  wire logic        analog_on,
   input  wire logic [15:0] conv_flag_pulse,
   input  wire logic [7:0]  command_index
);
   logic [8:0] on_cnt_r;
   logic       busy_r;

   always_ff @(posedge aclk) begin
      if (!aresetn || !analog_on) begin
         on_cnt_r <= 9'h000;
      end else if (on_cnt_r != 9'h1FF) begin
         on_cnt_r <= on_cnt_r + 9'h001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn || !analog_on) begin
         busy_r <= 1'b0;
      end else if (conv_start) begin
         busy_r <= 1'b1;
      end else if (conv_done) begin
         busy_r <= 1'b0;
      end
   end

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_ar_take;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence s_idle_two;
      !analog_on && !$past(analog_on);
   endsequence

   AST_RESET: assert property (disable iff (1'b0) !aresetn |=> !conv_start && !analog_on
      && conv_flag_pulse == 16'h0000 && command_index == 8'h00)
      else $error("outputs not cleared by reset");
   AST_FLAG_ZERO: assert property (!conv_flag_pulse[0])
      else $error("flag zero pulsed");
   AST_FLAG_ONE: assert property ($onehot0(conv_flag_pulse))
      else $error("more than one conversion flag pulsed");
   AST_FLAG_CAUSE: assert property (conv_flag_pulse != 16'h0000 |-> $past(conv_done)
      || $past(conv_done, 2))
      else $error("flag pulse without a finished conversion");
   AST_RECOVERY: assert property (conv_start |-> on_cnt_r >= 9'(REC_CYCLES - 4))
      else $error("conversion launched inside the recovery period");
   AST_DISCARD: assert property (s_idle_two |-> conv_flag_pulse == 16'h0000)
      else $error("result flagged while disabled");
   AST_ONE_CONV: assert property (conv_start |-> !busy_r)
      else $error("launch while a conversion is still running");
   AST_INDEX_STEP: assert property (analog_on && $past(analog_on) && $changed(command_index)
      |-> command_index == $past(command_index) + 8'h01 || command_index == 8'h00)
      else $error("command index moved other than by one step or wrap");
   AST_READ_LAT: assert property (s_ar_take |=> s_axi_rvalid)
      else $error("read answer late");
endmodule

bind acl_ctrl acl_ctrl_checker chk (.aclk, .aresetn, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .conv_done, .conv_start, .analog_on, .conv_flag_pulse, .command_index);

/* File: verif/acl_ctrl_tb.sv */
/*
 Self-checking bench for acl_ctrl: register gating, trigger flow, abort, soft reset, halts.
 Assumes acl_fe_model on the far side and acl_ctrl_checker bound to the design.
*/
`timescale 1ns/1ps
module acl_ctrl_tb
   import acl_pkg::*;
;
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin failures++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
   typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} acl_row_t;
   logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
   logic        s_axi_rready, conv_done, conv_start, analog_on, slow;
   logic [7:0]  s_axi_awaddr, s_axi_araddr, command_index;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
   logic [15:0] conv_flag_pulse, last_flag;
   acl_evt_t    evt_in;
   int          failures, checks_done, cyc, n_start, n_flag, s;
   acl_row_t    rows [9] = '{'{OFF_CTL0, 32'h63, 32'h63, RESP_OKAY},
      '{OFF_CTL0, 32'h8000, 32'h8000, RESP_OKAY}, '{OFF_CTL0, 32'h8063, 32'h8000, RESP_OKAY},
      '{OFF_CIDX, 32'h5, 32'h0, RESP_OKAY}, '{OFF_CTL1, 32'h1, 32'h1, RESP_OKAY},
      '{OFF_CMD0, 32'hC5000000, 32'hC5000000, RESP_OKAY}, '{OFF_CTL1, 32'h0, 32'h0, RESP_OKAY},
      '{OFF_CMD0, 32'h0, 32'hC5000000, RESP_OKAY}, '{8'h10, 32'h1, 32'h0, RESP_SLVERR}};

   acl_ctrl uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .evt_in, .conv_done, .conv_start, .analog_on, .conv_flag_pulse,
      .command_index);
   acl_fe_model fe (.aclk, .aresetn, .conv_start, .slow, .conv_done);

   always #2 aclk = ~aclk;

   always @(posedge aclk) begin
      cyc++;
      if (conv_start) n_start++;
      if (conv_flag_pulse != 16'h0000) begin
         n_flag++;
         last_flag = conv_flag_pulse;
      end
      if (cyc == 20000) begin
         failures++;
         stop_test();
      end
   end

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge aclk);
      s_axi_awaddr  <= a;
      s_axi_wdata   <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid  <= 1'b1;
      s_axi_bready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      rsp = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge aclk);
      s_axi_araddr  <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready  <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      rsp = s_axi_rresp;
      rdv = s_axi_rdata;
      s_axi_rready <= 1'b0;
   endtask

   // The trigger is held several cycles so the three-stage synchroniser cannot miss it.
   task automatic trig();
      s = n_start;
      @(posedge aclk);
      evt_in.trig <= 1'b1;
      repeat (6) @(posedge aclk);
      evt_in.trig <= 1'b0;
      repeat (70) @(posedge aclk);
   endtask

   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid} = '0;
      {s_axi_rready, slow, s_axi_awaddr, s_axi_araddr, s_axi_wdata, evt_in} = '0;
      {failures, checks_done, cyc, n_start, n_flag} = '0;
      s_axi_wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      `CHK(command_index, 8'h00)
      for (int i = 0; i < 9; i++) begin
         wr(rows[i].a, rows[i].d);
         `CHK(rsp, rows[i].r)
         rd(rows[i].a);
         `CHK(rsp, rows[i].r)
         if (rows[i].r == RESP_OKAY) `CHK(rdv, rows[i].q)
      end
      $display("test register table done");
      trig();
      `CHK(n_start, s)
      repeat (200) @(posedge aclk);
      wr(OFF_CTL1, 32'h1);
      for (int f = 1; f < 16; f++) begin
         slow <= f[0];
         wr(OFF_CMD0, {CMD_END_SEQ, 2'b00, 4'(f), 24'h0});
         trig();
         `CHK(n_start - s, 1)
         `CHK(last_flag, 16'h0001 << f)
      end
      wr(OFF_CMD0, {CMD_END_WAIT, 2'b00, 4'h3, 24'h0});
      trig();
      `CHK(n_start - s, 1)
      wr(OFF_CMD0, {CMD_END_WRAP, 2'b00, 4'h2, 24'h0});
      trig();
      `CHK(n_start - s > 1, 1'b1)
      $display("test trigger flow done");
      for (int m = 0; m < 4; m++) begin
         wr(OFF_CTL0, 32'h8000 | ((m % 2) << (13 - m / 2)));
         evt_in <= (m < 2) ? 8'h20 : 8'h10;
         repeat (80) @(posedge aclk);
         s = n_start;
         repeat (100) @(posedge aclk);
         `CHK(n_start - s > 0, m % 2 == 0)
         evt_in <= '0;
         repeat (10) @(posedge aclk);
      end
      wr(OFF_CTL0, 32'h8000);
      $display("test halts done");
      while (!conv_start) @(posedge aclk);
      wr(OFF_CTL0, 32'h0);
      s = n_flag;
      wr(OFF_CTL0, 32'h8000);
      rd(OFF_CTL0);
      `CHK(rdv[15], 1'b0)
      repeat (80) @(posedge aclk);
      `CHK(n_flag, s)
      `CHK(analog_on, 1'b0)
      wr(OFF_CTL1, 32'h5);
      rd(OFF_CTL1);
      `CHK(rdv, 32'h1)
      wr(OFF_CTL1, 32'hF);
      rd(OFF_CTL1);
      `CHK(rdv, 32'hF)
      wr(OFF_CTL0, 32'h8000);
      rd(OFF_CTL0);
      `CHK(rdv[15], 1'b1)
      repeat (260) @(posedge aclk);
      $display("test abort done");
      wr(OFF_CMD0, {CMD_END_SEQ, 2'b00, 4'h1, 24'h0});
      trig();
      `CHK(command_index, 8'h01)
      evt_in <= 8'h01;
      repeat (10) @(posedge aclk);
      evt_in <= '0;
      trig();
      `CHK(n_start, s)
      rd(OFF_ERR);
      `CHK(|rdv[3:0], 1'b1)
      wr(OFF_CTL0, 32'hC000);
      repeat (5) @(posedge aclk);
      rd(OFF_ERR);
      `CHK(rdv[11:0], 12'h000)
      `CHK(command_index, 8'h00)
      rd(OFF_CTL1);
      `CHK(rdv[3:2], 2'b00)
      rd(OFF_CTL0);
      `CHK(rdv[14], 1'b0)
      trig();
      `CHK(n_start - s, 1)
      $display("test soft reset done");
      stop_test();
   end
endmodule

/* File: verif/acl_fe_model.sv */
/*
 Behavioural analog front end: answers each conversion launch with one done pulse.
 Assumes conv_start is a one-cycle pulse on aclk; slow stretches the conversion.
*/
`timescale 1ns/1ps
module acl_fe_model
   import acl_pkg::*;
(
   input  wire logic aclk,
   input  wire logic aresetn,
   input  wire logic conv_start,
   input  wire logic slow,
   output logic      conv_done
);
   logic [7:0] cnt_r;
   logic       busy_r;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy_r <= 1'b0;
         cnt_r  <= 8'h00;
      end else if (conv_start) begin
         busy_r <= 1'b1;
         cnt_r  <= slow ? 8'(3 * CONV_CYCLES) : 8'(CONV_CYCLES);
      end else if (busy_r) begin
         cnt_r  <= cnt_r - 8'h01;
         busy_r <= (cnt_r != 8'h01);
      end
   end

   // The front end finishes even an aborted conversion; discarding it is the block's job.
   always_ff @(posedge aclk) begin
      conv_done <= aresetn && busy_r && (cnt_r == 8'h01);
   end
endmodule
